// [common/adc_seq_pkg.sv]
// constants for the converter sequencing block
// assumes a 25 MHz core clock and a 32-bit avalon-mm register bus
`default_nettype none
package adc_seq_pkg;
   // core clock period in ns
   localparam int CORE_CLK_NS = 40;
   // interrupt release time after a strobe fall, ns
   localparam int INT_CLR_NS = 175;
   localparam int INT_CLR_CYC = INT_CLR_NS / CORE_CLK_NS;
   // end-of-conversion fall after hold, ns, per start mode
   localparam int EOC_WR_NS = 350;
   localparam int EOC_WR_CYC = EOC_WR_NS / CORE_CLK_NS;
   localparam int EOC_SH_NS = 150;
   localparam int EOC_SH_CYC = EOC_SH_NS / CORE_CLK_NS;
   // phase lengths in conversion clock periods
   localparam logic [10:0] ACQ_TICKS = 11'h007;
   localparam logic [10:0] NULL_TICKS = 11'h01A;
   localparam logic [10:0] CONV_WR_TICKS = 11'h014;
   localparam logic [10:0] CONV_SH_TICKS = 11'h022;
   localparam logic [10:0] CAL_TICKS = 11'h577;
   // register word indices (byte address = 4 * index)
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_STATUS = 3'h1;
   localparam logic [2:0] REG_RESULT = 3'h2;
   localparam logic [2:0] REG_IRQ_STAT = 3'h3;
   localparam logic [2:0] REG_IRQ_MASK = 3'h4;
   // control fields
   localparam int CTRL_PIN_EN = 0;
   localparam int CTRL_SW_START = 1;
   localparam int CTRL_SW_CAL = 2;
   localparam logic CTRL_PIN_EN_RST = 1'h1;
   // status fields
   localparam int STAT_EOC = 8;
   localparam int STAT_INT_N = 9;
   localparam int STAT_BYTE_PTR = 10;
   // interrupt fields
   localparam int IRQ_CONV_DONE = 0;
   localparam int IRQ_CAL_DONE = 1;
   localparam logic [1:0] IRQ_MASK_RST = 2'h0;
   // synchroniser lanes of the pin vector
   localparam int PIN_SEL = 0;
   localparam int PIN_WR = 1;
   localparam int PIN_RD = 2;
   localparam int PIN_SH = 3;
   localparam int PIN_CAL = 4;
   localparam int PIN_NULL = 5;
   localparam int PIN_CLK = 6;
   localparam logic [6:0] PIN_RST = 7'h7F;
   // sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CAL = 6'h02,
      ST_NULL = 6'h04,
      ST_ACQ = 6'h08,
      ST_TRACK = 6'h10,
      ST_CONV = 6'h20
   } seq_state_e;
endpackage
`default_nettype wire

// [design/adc_conversion_timing_control.sv]
// sequencing logic of a self-calibrating 13-bit converter
// assumes pins are asynchronous to i_core_clk and an avalon-mm master
`timescale 1ns/1ps
`default_nettype none

module adc_conversion_timing_control (
   input wire logic i_core_clk, // core clock, 25 MHz
   input wire logic i_rstn, // synchronous reset, low
   input wire logic i_select_n, // device select pin
   input wire logic i_write_strobe_n, // write strobe pin
   input wire logic i_read_strobe_n, // read strobe pin
   input wire logic i_track_hold_n, // track/hold control pin
   input wire logic i_cal_request_n, // calibration request pin
   input wire logic i_offset_null_enable_n, // null pre-cycle pin
   input wire logic i_conversion_clock_in, // conversion clock pin
   input wire logic [12:0] i_sample_code, // code from analog core
   input wire logic [4:0] i_avs_address, // avalon byte address
   input wire logic i_avs_read, // avalon read
   input wire logic i_avs_write, // avalon write
   input wire logic [31:0] i_avs_writedata, // avalon write data
   output logic [31:0] o_avs_readdata, // avalon read data
   output logic o_avs_waitrequest, // avalon wait
   output logic o_eoc, // end-of-conversion flag
   output logic o_int_n, // result-ready interrupt, low
   output logic o_track, // acquisition window open
   output logic [7:0] o_result_byte_bus, // result byte out
   output logic o_result_byte_bus_oe, // byte bus drive enable
   output logic o_irq // level interrupt to software
);

   ////////////////////////////////////////////////////////////
   // pin synchronisers and edges
   logic [6:0] pin_raw; // gathered pins
   logic [6:0] sync1_reg; // first stage
   logic [6:0] sync2_reg; // second stage
   logic [6:0] prev_reg; // delayed for edges

   assign pin_raw = {i_conversion_clock_in, i_offset_null_enable_n,
      i_cal_request_n, i_track_hold_n, i_read_strobe_n,
      i_write_strobe_n, i_select_n};

   // two flops per pin, then one more for edges
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         sync1_reg <= adc_seq_pkg::PIN_RST;
         sync2_reg <= adc_seq_pkg::PIN_RST;
         prev_reg <= adc_seq_pkg::PIN_RST;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // rising and falling edge of one lane
   function automatic logic rise_of(input logic [6:0] cur,
      input logic [6:0] old, input int lane);
      rise_of = cur[lane] & ~old[lane];
   endfunction

   function automatic logic fall_of(input logic [6:0] cur,
      input logic [6:0] old, input int lane);
      fall_of = ~cur[lane] & old[lane];
   endfunction

   wire sel = ~sync2_reg[adc_seq_pkg::PIN_SEL]; // select held
   wire cal_low = ~sync2_reg[adc_seq_pkg::PIN_CAL]; // cal held
   wire null_on = ~sync2_reg[adc_seq_pkg::PIN_NULL]; // null wanted
   wire rd_low = ~sync2_reg[adc_seq_pkg::PIN_RD]; // read held
   wire tick = rise_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_CLK);
   wire wr_rise = rise_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_WR);
   wire wr_fall = fall_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_WR);
   wire rd_rise = rise_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_RD);
   wire rd_fall = fall_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_RD);
   wire sh_rise = rise_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_SH);
   wire sh_fall = fall_of(sync2_reg, prev_reg, adc_seq_pkg::PIN_SH);

   ////////////////////////////////////////////////////////////
   // software control state
   logic pin_en_reg; // pin starts accepted
   logic sw_start_reg; // one-cycle software start
   logic sw_cal_reg; // one-cycle software calibration
   logic [1:0] irq_stat_reg; // sticky events
   logic [1:0] irq_mask_reg; // event enables

   ////////////////////////////////////////////////////////////
   // sequencer
   adc_seq_pkg::seq_state_e state_reg; // current phase
   adc_seq_pkg::seq_state_e state_next; // next phase
   logic [10:0] cnt_reg; // ticks in phase
   logic [10:0] cnt_next; // next tick count
   logic sh_mode_reg; // conversion began from track/hold
   logic sh_mode_next; // next start mode
   logic [10:0] lim; // length of current phase

   wire idle = state_reg == adc_seq_pkg::ST_IDLE; // ready
   // calibration request overrides, acting as reset
   wire cal_go = cal_low | sw_cal_reg;
   // starts wait for a released calibration request
   wire wr_go = ((wr_rise & sel & pin_en_reg) | sw_start_reg)
      & idle & ~cal_low;
   wire sh_go = sh_fall & sel & pin_en_reg & idle & ~cal_low;
   wire last = tick & (cnt_reg == lim - 11'h001); // phase ends
   wire conv_done = (state_reg == adc_seq_pkg::ST_CONV) & last;
   wire cal_done = (state_reg == adc_seq_pkg::ST_CAL) & last & ~cal_go;
   wire [10:0] cnt_inc = tick ? 11'(cnt_reg + 11'h001) : cnt_reg;

   // phase length by state and start mode
   always_comb begin
      case (state_reg)
         adc_seq_pkg::ST_CAL: lim = adc_seq_pkg::CAL_TICKS;
         adc_seq_pkg::ST_NULL: lim = adc_seq_pkg::NULL_TICKS;
         adc_seq_pkg::ST_ACQ: lim = adc_seq_pkg::ACQ_TICKS;
         adc_seq_pkg::ST_CONV: lim = sh_mode_reg
            ? adc_seq_pkg::CONV_SH_TICKS
            : adc_seq_pkg::CONV_WR_TICKS;
         default: lim = 11'h7FF;
      endcase
   end

   // next phase; counts conversion clock rising edges
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_inc;
      sh_mode_next = sh_mode_reg;
      case (state_reg)
         adc_seq_pkg::ST_IDLE: begin
            cnt_next = 11'h000;
            if (wr_go) begin
               // null pre-cycle inserted when requested
               state_next = null_on ? adc_seq_pkg::ST_NULL
                  : adc_seq_pkg::ST_ACQ;
               sh_mode_next = 1'b0;
            end else if (sh_go) begin
               state_next = adc_seq_pkg::ST_TRACK;
            end
         end
         adc_seq_pkg::ST_CAL: begin
            if (last) begin
               state_next = adc_seq_pkg::ST_IDLE;
            end
         end
         adc_seq_pkg::ST_NULL: begin
            if (last) begin
               state_next = adc_seq_pkg::ST_ACQ;
               cnt_next = 11'h000;
            end
         end
         adc_seq_pkg::ST_ACQ: begin
            // window closes on the seventh clock rise
            if (last) begin
               state_next = adc_seq_pkg::ST_CONV;
               cnt_next = 11'h000;
            end
         end
         adc_seq_pkg::ST_TRACK: begin
            cnt_next = 11'h000;
            // hold at once on the control's rise
            if (sh_rise) begin
               state_next = adc_seq_pkg::ST_CONV;
               sh_mode_next = 1'b1;
            end
         end
         adc_seq_pkg::ST_CONV: begin
            if (last) begin
               state_next = adc_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_next = adc_seq_pkg::ST_IDLE;
         end
      endcase
      // calibration request restarts the count
      if (cal_go) begin
         state_next = adc_seq_pkg::ST_CAL;
         cnt_next = 11'h000;
      end
   end

   // sequencer registers
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         state_reg <= adc_seq_pkg::ST_IDLE;
         cnt_reg <= 11'h000;
         sh_mode_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_mode_reg <= sh_mode_next;
      end
   end

   ////////////////////////////////////////////////////////////
   // flags toward the host pins
   wire eoc_next = ~(state_next == adc_seq_pkg::ST_CAL
      | state_next == adc_seq_pkg::ST_CONV);
   wire int_clr = ((rd_fall | wr_fall) & sel) | cal_go | wr_go | sh_go;

   // end flag, track window and interrupt pin
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         o_eoc <= 1'b1;
         o_track <= 1'b0;
         o_int_n <= 1'b1;
      end else begin
         o_eoc <= eoc_next;
         o_track <= state_next == adc_seq_pkg::ST_ACQ
            | state_next == adc_seq_pkg::ST_TRACK;
         // completion wins over a same-cycle release
         if (conv_done) begin
            o_int_n <= 1'b0;
         end else if (int_clr) begin
            o_int_n <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // result latch and byte reads
   logic [12:0] result_reg; // latched code
   logic byte_ptr_reg; // 0: high byte next

   wire [7:0] high_byte = {{3{result_reg[12]}}, result_reg[12:8]};

   // latch on completion, step the byte on read release
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         result_reg <= 13'h0000;
         byte_ptr_reg <= 1'b0;
         o_result_byte_bus <= 8'h00;
         o_result_byte_bus_oe <= 1'b0;
      end else begin
         if (conv_done) begin
            result_reg <= i_sample_code;
            byte_ptr_reg <= 1'b0;
         end else if (rd_rise & sel) begin
            byte_ptr_reg <= ~byte_ptr_reg;
         end
         o_result_byte_bus <= byte_ptr_reg ? result_reg[7:0]
            : high_byte;
         o_result_byte_bus_oe <= rd_low & sel;
      end
   end

   ////////////////////////////////////////////////////////////
   // avalon-mm slave, one wait cycle per access
   wire req = i_avs_read | i_avs_write; // request held
   wire acc = req & ~o_avs_waitrequest; // access taken now
   wire [2:0] widx = i_avs_address[4:2]; // word index
   wire wr_ctrl = acc & i_avs_write & (widx == adc_seq_pkg::REG_CTRL);
   wire wr_istat = acc & i_avs_write
      & (widx == adc_seq_pkg::REG_IRQ_STAT);
   wire wr_imask = acc & i_avs_write
      & (widx == adc_seq_pkg::REG_IRQ_MASK);
   wire [1:0] irq_set = {cal_done, conv_done};
   wire [1:0] irq_clr = wr_istat ? i_avs_writedata[1:0] : 2'h0;
   logic [31:0] rdata; // read mux

   // read selection; unmapped reads as zero
   always_comb begin
      rdata = 32'h00000000;
      case (widx)
         adc_seq_pkg::REG_CTRL:
            rdata[adc_seq_pkg::CTRL_PIN_EN] = pin_en_reg;
         adc_seq_pkg::REG_STATUS: begin
            rdata[5:0] = state_reg;
            rdata[adc_seq_pkg::STAT_EOC] = o_eoc;
            rdata[adc_seq_pkg::STAT_INT_N] = o_int_n;
            rdata[adc_seq_pkg::STAT_BYTE_PTR] = byte_ptr_reg;
         end
         adc_seq_pkg::REG_RESULT: rdata[12:0] = result_reg;
         adc_seq_pkg::REG_IRQ_STAT: rdata[1:0] = irq_stat_reg;
         adc_seq_pkg::REG_IRQ_MASK: rdata[1:0] = irq_mask_reg;
         default: rdata = 32'h00000000;
      endcase
   end

   // bus handshake and register writes
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata <= 32'h00000000;
         pin_en_reg <= adc_seq_pkg::CTRL_PIN_EN_RST;
         sw_start_reg <= 1'b0;
         sw_cal_reg <= 1'b0;
         irq_mask_reg <= adc_seq_pkg::IRQ_MASK_RST;
      end else begin
         // drop wait for one cycle after a request appears
         o_avs_waitrequest <= ~(req & o_avs_waitrequest);
         if (req & o_avs_waitrequest) begin
            o_avs_readdata <= rdata;
         end
         sw_start_reg <= wr_ctrl
            & i_avs_writedata[adc_seq_pkg::CTRL_SW_START];
         sw_cal_reg <= wr_ctrl & i_avs_writedata[adc_seq_pkg::CTRL_SW_CAL];
         if (wr_ctrl) begin
            pin_en_reg <= i_avs_writedata[adc_seq_pkg::CTRL_PIN_EN];
         end
         if (wr_imask) begin
            irq_mask_reg <= i_avs_writedata[1:0];
         end
      end
   end

   // sticky events, set wins over write-one clear
   always_ff @(posedge i_core_clk) begin
      if (!i_rstn) begin
         irq_stat_reg <= 2'h0;
         o_irq <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         o_irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rstn);

   chk_int_release: assert property (
      ((rd_fall | wr_fall) & sel & ~conv_done) |=> o_int_n)
      else $error("interrupt not released after strobe fall");

   chk_eoc_track_hold: assert property (
      (state_reg == adc_seq_pkg::ST_TRACK && sh_rise && !cal_go)
      |=> !o_eoc && state_reg == adc_seq_pkg::ST_CONV)
      else $error("end flag did not fall after hold");

   chk_acq_window: assert property (
      state_reg == adc_seq_pkg::ST_ACQ |-> cnt_reg < 11'h007)
      else $error("acquisition window too long");

   chk_null_window: assert property (
      state_reg == adc_seq_pkg::ST_NULL |-> cnt_reg < 11'h01A)
      else $error("null pre-cycle too long");

   chk_cal_flag: assert property (
      $rose(state_reg == adc_seq_pkg::ST_CAL)
      |=> !o_eoc [*8])
      else $error("end flag high during calibration");

   chk_wr_start: assert property (
      (wr_rise && sel && pin_en_reg && idle && !cal_go)
      |=> (state_reg == adc_seq_pkg::ST_ACQ
         || state_reg == adc_seq_pkg::ST_NULL))
      else $error("write strobe did not start conversion");

   chk_track_open: assert property (
      (sh_go && !wr_go && !cal_go)
      |=> state_reg == adc_seq_pkg::ST_TRACK && o_track)
      else $error("track/hold fall did not open window");

   chk_conv_len: assert property (
      (state_reg == adc_seq_pkg::ST_CONV && !sh_mode_reg)
      |-> cnt_reg < 11'h014)
      else $error("strobe conversion too long");

   chk_conv_sh_len: assert property (
      (state_reg == adc_seq_pkg::ST_CONV && sh_mode_reg)
      |-> cnt_reg < 11'h022)
      else $error("track/hold conversion too long");

   chk_cal_blocks: assert property (
      cal_low |=> state_reg == adc_seq_pkg::ST_CAL)
      else $error("start accepted under calibration request");

   chk_high_first: assert property (
      conv_done |=> ##1 o_result_byte_bus == {{3{result_reg[12]}},
         result_reg[12:8]})
      else $error("high byte not presented first");

   chk_done_int: assert property (
      (conv_done && !cal_go) |=> !o_int_n && o_eoc)
      else $error("completion not flagged");

endmodule // adc_conversion_timing_control
`default_nettype wire

// [dv/host_pin_model.sv]
// host side of the converter pins: strobes, track/hold, calibration, clock
// assumes every task is entered just after a rising core clock edge
`timescale 1ns/1ps
`default_nettype none
module host_pin_model #(
   parameter int TICK_HALF = 5 // core cycles per half tick
) (
   input wire logic i_core_clk, // shared core clock
   output logic o_select_n, // device select
   output logic o_write_strobe_n, // write strobe
   output logic o_read_strobe_n, // read strobe
   output logic o_track_hold_n, // track/hold control
   output logic o_cal_request_n, // calibration request
   output logic o_offset_null_enable_n, // null pre-cycle select
   output logic o_conversion_clock_in // free-running tick clock
);
   int tick_cnt; // half period counter
   ////////////////////////////////////////////////////////////////////
   // all pins except the tick clock idle high at time zero; the tick clock starts low
   initial begin
      o_select_n = 1'b1;
      o_write_strobe_n = 1'b1;
      o_read_strobe_n = 1'b1;
      o_track_hold_n = 1'b1;
      o_cal_request_n = 1'b1;
      o_offset_null_enable_n = 1'b1;
      o_conversion_clock_in = 1'b0;
      tick_cnt = 0;
   end
   // tick clock runs free, well below the core rate
   always @(posedge i_core_clk) begin
      if (tick_cnt == TICK_HALF - 1) begin
         tick_cnt <= 0;
         o_conversion_clock_in <= ~o_conversion_clock_in;
      end else begin
         tick_cnt <= tick_cnt + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic hold_cycles(input int n);
      repeat (n) @(posedge i_core_clk);
   endtask
   // write pulse; null choice stays put through the sequence
   task automatic strobe_start(input logic sel_n, input logic null_n);
      o_offset_null_enable_n <= null_n;
      o_select_n <= sel_n;
      o_write_strobe_n <= 1'b0;
      hold_cycles(6); // pulse wider than 200 ns
      o_write_strobe_n <= 1'b1;
      hold_cycles(2);
      o_select_n <= 1'b1;
      hold_cycles(1);
   endtask
   // one byte read, select framing the strobe
   task automatic read_byte();
      o_select_n <= 1'b0;
      o_read_strobe_n <= 1'b0;
      hold_cycles(6);
      o_read_strobe_n <= 1'b1;
      hold_cycles(2);
      o_select_n <= 1'b1;
      hold_cycles(1);
   endtask
   // track/hold: open window, then hold edge, then drop select
   task automatic sh_open();
      o_select_n <= 1'b0;
      o_track_hold_n <= 1'b0;
   endtask
   task automatic sh_close();
      o_track_hold_n <= 1'b1;
   endtask
   task automatic deselect();
      o_select_n <= 1'b1;
      hold_cycles(1);
   endtask
   // calibration request, always back high before any start
   task automatic cal_low();
      o_cal_request_n <= 1'b0;
   endtask
   task automatic cal_high();
      o_cal_request_n <= 1'b1;
   endtask
endmodule // host_pin_model
`default_nettype wire

// [dv/tb_adc_conversion_timing_control.sv]
// self-checking bench of the converter sequencer
// assumes the host pin model and the design package are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module tb_adc_conversion_timing_control;
   localparam int T = 10; // core cycles per tick
   logic i_core_clk, rstn, sel_n, wr_n, rd_n, sh_n, cal_n, null_n, tick;
   logic [12:0] sample_code; // code handed to the sequencer
   logic [4:0] avs_address;
   logic avs_read, avs_write, oe_q;
   logic [31:0] avs_writedata, o_avs_readdata;
   logic o_avs_waitrequest, o_eoc, o_int_n, o_track, o_oe, o_irq;
   logic [7:0] o_byte;
   logic [31:0] eb; // popped expectation
   logic [31:0] exp_bus[$]; // expected read data
   logic [31:0] exp_byte[$]; // expected result bytes
   int err_count = 0;
   int num_checks = 0;
   int sd;
   wire logic [3:0] mon = {o_oe, o_eoc, o_track, o_int_n}; // watched flags
   ////////////////////////////////////////////////////////////////////
   adc_conversion_timing_control i_dut (
      .i_core_clk(i_core_clk), .i_rstn(rstn), .i_select_n(sel_n), .i_write_strobe_n(wr_n),
      .i_read_strobe_n(rd_n), .i_track_hold_n(sh_n), .i_cal_request_n(cal_n),
      .i_offset_null_enable_n(null_n), .i_conversion_clock_in(tick), .i_sample_code(sample_code),
      .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
      .i_avs_writedata(avs_writedata), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .o_eoc(o_eoc), .o_int_n(o_int_n), .o_track(o_track),
      .o_result_byte_bus(o_byte), .o_result_byte_bus_oe(o_oe), .o_irq(o_irq));
   host_pin_model #(.TICK_HALF(T / 2)) i_host (
      .i_core_clk(i_core_clk), .o_select_n(sel_n), .o_write_strobe_n(wr_n), .o_read_strobe_n(rd_n),
      .o_track_hold_n(sh_n), .o_cal_request_n(cal_n), .o_offset_null_enable_n(null_n),
      .o_conversion_clock_in(tick));
   ////////////////////////////////////////////////////////////////////
   // 25 MHz core clock
   initial begin
      i_core_clk = 1'b0;
      forever #20 i_core_clk = ~i_core_clk;
   end
   // monitor: takes the oldest note whenever a result shows
   always @(posedge i_core_clk) begin
      oe_q <= o_oe;
      if (avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
         eb = exp_bus.pop_front();
         `CHK(o_avs_readdata, eb)
      end
      if (o_oe === 1'b1 && oe_q === 1'b0) begin
         eb = exp_byte.pop_front();
         `CHK(o_byte, eb[7:0])
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (err_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic in_rng(input int v, input int lo, input int hi);
      return v >= lo && v <= hi;
   endfunction
   // bounded wait on one flag, counting edges
   task automatic wait_for(input int which, input logic val, input int limit, output int cyc);
      cyc = 0;
      do begin
         @(posedge i_core_clk);
         cyc++;
      end while (mon[which] !== val && cyc < limit);
      if (mon[which] !== val) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, mon[which], val);
         stop_test();
      end
   endtask
   // one avalon access; data is write data or the expected read data
   task automatic bus_cycle(input logic rd, input logic [2:0] idx, input logic [31:0] d);
      int n;
      n = 0;
      if (rd) begin
         exp_bus.push_back(d);
      end
      avs_read <= rd;
      avs_write <= ~rd;
      avs_address <= {idx, 2'h0};
      avs_writedata <= d;
      do begin
         @(posedge i_core_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 50);
      if (o_avs_waitrequest !== 1'b0) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, o_avs_waitrequest, 1'b0);
         stop_test();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge i_core_clk);
   endtask
   // two result reads, the first also times the interrupt release
   task automatic read_pair(input logic [12:0] c);
      int cyc;
      exp_byte.push_back({24'h0, {3{c[12]}}, c[12:8]});
      exp_byte.push_back({24'h0, c[7:0]});
      fork
         i_host.read_byte();
         wait_for(0, 1'b1, 20, cyc);
      join
      `CHK(cyc <= adc_seq_pkg::INT_CLR_CYC + 1, 1'b1)
      i_host.read_byte();
   endtask
   // write strobe conversion, with or without the null pre-cycle
   task automatic conv_strobe(input logic nl);
      int a, b, c, d;
      logic [12:0] code;
      code = 13'($urandom);
      sample_code <= code;
      i_host.strobe_start(1'b0, nl);
      wait_for(1, 1'b1, 30 * T, a);
      wait_for(1, 1'b0, 8 * T, b);
      wait_for(2, 1'b0, 10, c);
      `CHK(c <= adc_seq_pkg::EOC_WR_CYC + 1, 1'b1)
      wait_for(0, 1'b0, 25 * T, d);
      if (nl) begin
         `CHK(b <= 7 * T, 1'b1)
         `CHK(in_rng(a + b + 3, 6 * T, 7 * T + 8), 1'b1)
         `CHK(in_rng(a + b + c + d + 3, 26 * T, 27 * T + 8), 1'b1)
      end else begin
         `CHK(in_rng(a + b + 3, 32 * T, 33 * T + 8), 1'b1)
      end
      read_pair(code);
   endtask
   // track/hold conversion
   task automatic conv_track();
      int a, c, d;
      logic [12:0] code;
      code = 13'($urandom);
      sample_code <= code;
      i_host.sh_open();
      wait_for(1, 1'b1, 8, a);
      `CHK(a <= 5, 1'b1)
      repeat (40) @(posedge i_core_clk);
      i_host.sh_close();
      wait_for(2, 1'b0, 8, c);
      `CHK(c <= adc_seq_pkg::EOC_SH_CYC + 1, 1'b1)
      `CHK(o_track, 1'b0)
      wait_for(0, 1'b0, 36 * T, d);
      `CHK(in_rng(c + d, 33 * T, 34 * T + 8), 1'b1)
      i_host.deselect();
      read_pair(code);
   endtask
   // calibration: flag low at once, high after the counted cycle
   task automatic do_cal();
      int c;
      i_host.cal_low();
      wait_for(2, 1'b0, 8, c);
      `CHK(o_eoc, 1'b0)
      repeat (4) @(posedge i_core_clk);
      i_host.cal_high();
      wait_for(2, 1'b1, 1400 * T, c);
      `CHK(in_rng(c, 1398 * T, 1399 * T + 8), 1'b1)
   endtask
   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rstn = 1'b0;
      sample_code = 13'h0000;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      oe_q = 1'b0;
      sd = $urandom(44762);
      repeat (4) @(posedge i_core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      bus_cycle(1'b1, adc_seq_pkg::REG_CTRL, 32'h1);
      bus_cycle(1'b1, adc_seq_pkg::REG_STATUS, 32'h301);
      bus_cycle(1'b1, adc_seq_pkg::REG_IRQ_MASK, 32'h0);
      bus_cycle(1'b1, 3'h7, 32'h0); // unmapped word
      do_cal();
      bus_cycle(1'b1, adc_seq_pkg::REG_IRQ_STAT, 32'h2);
      bus_cycle(1'b0, adc_seq_pkg::REG_IRQ_STAT, 32'h2);
      bus_cycle(1'b1, adc_seq_pkg::REG_IRQ_STAT, 32'h0);
      conv_strobe(1'b1);
      conv_strobe(1'b1);
      conv_strobe(1'b0);
      conv_track();
      // starts refused: select high, then pin start disabled
      for (int i = 0; i < 2; i++) begin
         bus_cycle(1'b0, adc_seq_pkg::REG_CTRL, {31'h0, i == 0});
         i_host.strobe_start(i == 0, 1'b1);
         repeat (30) begin
            @(posedge i_core_clk);
            `CHK(o_track, 1'b0)
         end
      end
      bus_cycle(1'b0, adc_seq_pkg::REG_CTRL, 32'h3);
      wait_for(0, 1'b0, 40 * T, sd);
      bus_cycle(1'b1, adc_seq_pkg::REG_IRQ_STAT, 32'h1);
      `CHK(o_irq, 1'b0)
      bus_cycle(1'b0, adc_seq_pkg::REG_IRQ_MASK, 32'h1);
      repeat (2) @(posedge i_core_clk);
      `CHK(o_irq, 1'b1)
      bus_cycle(1'b0, adc_seq_pkg::REG_IRQ_STAT, 32'h1);
      repeat (2) @(posedge i_core_clk);
      `CHK(o_irq, 1'b0)
      // software calibration through the control word
      bus_cycle(1'b0, adc_seq_pkg::REG_CTRL, 32'h5);
      wait_for(2, 1'b0, 8, sd);
      wait_for(2, 1'b1, 1400 * T, sd);
      `CHK(in_rng(sd, 1398 * T, 1399 * T + 8), 1'b1)
      bus_cycle(1'b1, adc_seq_pkg::REG_IRQ_STAT, 32'h2);
      do_cal();
      stop_test();
   end
endmodule // tb_adc_conversion_timing_control
`default_nettype wire
